// File: rtl/ufc_pkg.sv
// constants shared by both ends of the function-control register link
// assumes both ends run on one common clock hclk
package ufc_pkg;
   // ----------------------------------------
   // register addresses and fields
   // ----------------------------------------
   localparam logic [5:0] UFC_ADDR_WRITE = 6'h04;
   localparam logic [5:0] UFC_ADDR_SET   = 6'h05;
   localparam logic [5:0] UFC_ADDR_CLEAR = 6'h06;
   localparam logic [7:0] UFC_RESET_VAL  = 8'h41;
   localparam int         UFC_SUSP_BIT   = 6;
   localparam int         UFC_XRST_BIT   = 5;
   localparam int         UFC_OPM_LSB    = 3;
   localparam int         UFC_TERM_BIT   = 2;
   localparam int         UFC_SPD_LSB    = 0;
   localparam logic [1:0] UFC_OPM_NORMAL = 2'h0;
   localparam logic [1:0] UFC_OPM_NODRV  = 2'h1;
   localparam logic [1:0] UFC_OPM_RAW    = 2'h2;
   localparam logic [1:0] UFC_OPM_NOSYNC = 2'h3;
   localparam logic [1:0] UFC_SPD_HS     = 2'h0;
   localparam logic [1:0] UFC_SPD_FS     = 2'h1;
   localparam logic [1:0] UFC_SPD_LS     = 2'h2;
   localparam logic [1:0] UFC_SPD_FSLS   = 2'h3;
   // ----------------------------------------
   // bus command codes in the top two bits
   // ----------------------------------------
   localparam logic [1:0] UFC_CMD_WRITE  = 2'h2;
   localparam logic [1:0] UFC_CMD_READ   = 2'h3;
   // ----------------------------------------
   // core reset timing
   // ----------------------------------------
   localparam int         UFC_CLK_NS     = 100;
   localparam int         UFC_CRST_NS    = 1000;
   localparam int         UFC_CRST_CYC   = (UFC_CRST_NS + UFC_CLK_NS - 1) / UFC_CLK_NS;
   // ----------------------------------------
   // controller registers on the software bus
   // ----------------------------------------
   localparam logic [7:0] UFC_AHB_CTRL   = 8'h00;
   localparam logic [7:0] UFC_AHB_STAT   = 8'h04;
   localparam logic [1:0] UFC_OP_NONE    = 2'h0;
   localparam logic [1:0] UFC_OP_WRITE   = 2'h1;
   localparam logic [1:0] UFC_OP_READ    = 2'h2;
   localparam logic [1:0] UFC_OP_WAKE    = 2'h3;
endpackage

// File: rtl/ufc_ulpi_if.sv
// link wires between the controller end and the transceiver end
// assumes both ends are clocked by hclk; bus level resolved here
`timescale 1ns/1ps
interface ufc_ulpi_if
(
   input wire logic hclk
);
   logic       dir;
   logic       nxt;
   logic       stp;
   logic [7:0] link_dout;
   logic       link_doe;
   logic [7:0] phy_dout;
   logic       phy_doe;
   logic [7:0] data;

   // transceiver drive wins; an undriven bus reads as zero
   assign data = phy_doe ? phy_dout : (link_doe ? link_dout : 8'h00);

   modport phy
   (
      input  hclk, stp, data,
      output dir, nxt, phy_dout, phy_doe
   );
   modport link
   (
      input  hclk, dir, nxt, data,
      output stp, link_dout, link_doe
   );
endinterface

// File: rtl/ufc_link.sv
// controller end: takes orders over ahb-lite and runs register
// transfers on the link; assumes one slave on the bus, hclk common
`timescale 1ns/1ps
module ufc_link
   import ufc_pkg::*;
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   ufc_ulpi_if.link         ulpi,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output      logic        hreadyout,
   output      logic        hresp,
   output      logic [31:0] hrdata
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum logic [3:0] {L_IDLE, L_CMD, L_DATA, L_STOP, L_RTURN, L_RDATA,
                             L_WAITHI, L_WAITLO, L_WAKE} ufc_link_st_e;
   typedef struct packed {
      ufc_link_st_e st;
      logic         ahb_wr;
      logic [7:0]   ahb_addr;
      logic [31:0]  hrdata;
      logic         hready;
      logic [1:0]   op;
      logic [5:0]   addr;
      logic [7:0]   wdata;
      logic [7:0]   rdata;
      logic [7:0]   rxcmd;
      logic         busy;
      logic         rwait;
      logic         dir_q;
      logic         stp;
      logic [7:0]   dout;
      logic         doe;
   } ufc_link_s;

   ufc_link_s q_ff;
   ufc_link_s nxt_q;

   function automatic logic [31:0] ufc_link_rd(input ufc_link_s s, input logic [7:0] a);
      logic [31:0] r;
      r = 32'h0;
      if (a == UFC_AHB_CTRL)
         r = {14'h0, s.op, 2'h0, s.addr, s.wdata};
      else if (a == UFC_AHB_STAT)
         r = {8'h0, s.rxcmd, s.rdata, 5'h0, s.rwait, s.dir_q, s.busy};
      return r;
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      nxt_q = q_ff;
      nxt_q.hready = 1'b1;
      nxt_q.dir_q = ulpi.dir;
      nxt_q.ahb_wr = 1'b0;
      // address phase; read data prepared now so hrdata comes from a flop
      if (hsel && htrans[1] && hready)
      begin
         nxt_q.ahb_wr = hwrite;
         nxt_q.ahb_addr = haddr[7:0];
         if (!hwrite)
            nxt_q.hrdata = ufc_link_rd(q_ff, haddr[7:0]);
      end
      // orders arriving while busy are dropped
      if (q_ff.ahb_wr && q_ff.ahb_addr == UFC_AHB_CTRL && !q_ff.busy)
      begin
         nxt_q.wdata = hwdata[7:0];
         nxt_q.addr = hwdata[13:8];
         nxt_q.op = hwdata[17:16];
         nxt_q.busy = (hwdata[17:16] != UFC_OP_NONE);
      end
      case (q_ff.st)
         L_IDLE:
         begin
            if (ulpi.dir && q_ff.dir_q && !ulpi.nxt)
               nxt_q.rxcmd = ulpi.data;
            if (q_ff.busy && q_ff.op == UFC_OP_WAKE)
            begin
               nxt_q.stp = 1'b1;
               nxt_q.st = L_WAKE;
            end
            else if (q_ff.busy && !ulpi.dir && !q_ff.dir_q)
            begin
               nxt_q.doe = 1'b1;
               nxt_q.dout = {(q_ff.op == UFC_OP_WRITE) ? UFC_CMD_WRITE : UFC_CMD_READ, q_ff.addr};
               nxt_q.st = L_CMD;
            end
         end
         L_CMD:
         begin
            if (ulpi.dir)
            begin
               nxt_q.doe = 1'b0;
               nxt_q.st = L_IDLE;
            end
            else if (ulpi.nxt && q_ff.op == UFC_OP_WRITE)
            begin
               nxt_q.dout = q_ff.wdata;
               nxt_q.st = L_DATA;
            end
            else if (ulpi.nxt)
            begin
               nxt_q.doe = 1'b0;
               nxt_q.st = L_RTURN;
            end
         end
         L_DATA:
         begin
            if (ulpi.nxt)
            begin
               nxt_q.dout = 8'h00;
               nxt_q.stp = 1'b1;
               nxt_q.st = L_STOP;
            end
         end
         L_STOP:
         begin
            nxt_q.stp = 1'b0;
            nxt_q.doe = 1'b0;
            if (q_ff.wdata[UFC_XRST_BIT] && (q_ff.addr == UFC_ADDR_WRITE || q_ff.addr == UFC_ADDR_SET))
            begin
               nxt_q.rwait = 1'b1;
               nxt_q.st = L_WAITHI;
            end
            else
            begin
               nxt_q.busy = 1'b0;
               nxt_q.st = L_IDLE;
            end
         end
         L_RTURN:
            if (ulpi.dir)
               nxt_q.st = L_RDATA;
         L_RDATA:
         begin
            nxt_q.rdata = ulpi.data;
            nxt_q.busy = 1'b0;
            nxt_q.st = L_IDLE;
         end
         L_WAITHI:
            if (ulpi.dir)
               nxt_q.st = L_WAITLO;
         L_WAITLO:
            if (!ulpi.dir)
            begin
               nxt_q.rwait = 1'b0;
               nxt_q.busy = 1'b0;
               nxt_q.st = L_IDLE;
            end
         L_WAKE:
            if (!ulpi.dir)
            begin
               nxt_q.stp = 1'b0;
               nxt_q.busy = 1'b0;
               nxt_q.st = L_IDLE;
            end
         default:
            nxt_q.st = L_IDLE;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         q_ff <= '0;
      else if (ce)
         q_ff <= nxt_q;
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign hreadyout = q_ff.hready;
   assign hresp = 1'b0;
   assign hrdata = q_ff.hrdata;
   assign ulpi.stp = q_ff.stp;
   assign ulpi.link_dout = q_ff.dout;
   assign ulpi.link_doe = q_ff.doe;
endmodule

// File: rtl/ufc_phy.sv
// transceiver end: function-control register and the transfers that reach it
// assumes the controller shares hclk, so link pins need no synchroniser
//
// Chosen here: register access over AHB-Lite.
`timescale 1ns/1ps
module ufc_phy
   import ufc_pkg::*;
#(
   parameter int CRST_CYC = UFC_CRST_CYC
)
(
   input  wire logic       hclk,
   input  wire logic       hresetn,
   input  wire logic       ce,
   ufc_ulpi_if.phy         ulpi,
   input  wire logic [1:0] line_state,
   input  wire logic       plus_line_pulldown_enable,
   input  wire logic       minus_line_pulldown_enable,
   output      logic [7:0] phy_function_control,
   output      logic       low_power,
   output      logic       core_reset,
   output      logic       fs_rx_en,
   output      logic       hs_xcvr_en,
   output      logic       fs_xcvr_en,
   output      logic       ls_xcvr_en,
   output      logic       fs_preamble_en,
   output      logic       tx_non_driving,
   output      logic       tx_raw_encoding,
   output      logic       tx_no_sync_eop,
   output      logic       fs_pullup_en,
   output      logic       hs_term_en
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef enum logic [3:0] {D_IDLE, D_WACK, D_WDATA, D_WSTOP, D_RACK, D_RTURN,
                             D_RDATA, D_RESET, D_RXTURN, D_RXDRV, D_SUSP} ufc_phy_st_e;
   typedef struct packed {
      ufc_phy_st_e st;
      logic [7:0]  fc;
      logic [5:0]  addr;
      logic [15:0] cnt;
      logic        dir;
      logic        nxt;
      logic [7:0]  dout;
      logic        doe;
      logic        lp;
      logic        crst;
      logic        hs;
      logic        fs;
      logic        ls;
      logic        pre;
      logic        nd;
      logic        raw;
      logic        nse;
      logic        pu;
      logic        ht;
      logic [3:0]  ls_sync;
   } ufc_phy_s;

   localparam logic [15:0] CRST_LAST = 16'(CRST_CYC - 1);
   ufc_phy_s q_ff;
   ufc_phy_s nxt_q;

   function automatic logic [7:0] ufc_apply(input logic [7:0] cur, input logic [5:0] a,
                                            input logic [7:0] d);
      logic [7:0] r;
      r = cur;
      if (a == UFC_ADDR_WRITE)
         r = d;
      else if (a == UFC_ADDR_SET)
         r = cur | d;
      else if (a == UFC_ADDR_CLEAR)
         r = cur & ~d;
      return r;
   endfunction
   function automatic logic ufc_readable(input logic [5:0] a);
      return (a == UFC_ADDR_WRITE) || (a == UFC_ADDR_SET) || (a == UFC_ADDR_CLEAR);
   endfunction
   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      logic [1:0] spd;
      logic [1:0] opm;
      logic       live;
      spd = 2'h0;
      opm = 2'h0;
      live = 1'b0;
      nxt_q = q_ff;
      nxt_q.ls_sync = {q_ff.ls_sync[1:0], line_state};
      case (q_ff.st)
         D_IDLE:
         begin
            if (q_ff.fc[UFC_XRST_BIT])
            begin
               nxt_q.dir = 1'b1;
               nxt_q.crst = 1'b1;
               nxt_q.cnt = 16'h0;
               nxt_q.st = D_RESET;
            end
            else if (!q_ff.fc[UFC_SUSP_BIT])
            begin
               nxt_q.dir = 1'b1;
               nxt_q.lp = 1'b1;
               nxt_q.st = D_SUSP;
            end
            else if (ulpi.data[7:6] == UFC_CMD_WRITE)
            begin
               nxt_q.addr = ulpi.data[5:0];
               nxt_q.nxt = 1'b1;
               nxt_q.st = D_WACK;
            end
            else if (ulpi.data[7:6] == UFC_CMD_READ)
            begin
               nxt_q.addr = ulpi.data[5:0];
               nxt_q.nxt = 1'b1;
               nxt_q.st = D_RACK;
            end
         end
         D_WACK:
            nxt_q.st = D_WDATA;
         D_WDATA:
         begin
            nxt_q.fc = ufc_apply(q_ff.fc, q_ff.addr, ulpi.data);
            nxt_q.nxt = 1'b0;
            nxt_q.st = D_WSTOP;
         end
         D_WSTOP:
            if (ulpi.stp)
               nxt_q.st = D_IDLE;
         D_RACK:
         begin
            nxt_q.nxt = 1'b0;
            nxt_q.dir = 1'b1;
            nxt_q.st = D_RTURN;
         end
         D_RTURN:
         begin
            // turnaround cycle: dir high, bus still undriven
            nxt_q.dout = ufc_readable(q_ff.addr) ? q_ff.fc : 8'h00;
            nxt_q.doe = 1'b1;
            nxt_q.st = D_RDATA;
         end
         D_RDATA:
         begin
            nxt_q.dir = 1'b0;
            nxt_q.doe = 1'b0;
            nxt_q.st = D_IDLE;
         end
         D_RESET:
         begin
            if (q_ff.cnt == CRST_LAST)
            begin
               nxt_q.dir = 1'b0;
               nxt_q.crst = 1'b0;
               nxt_q.fc[UFC_XRST_BIT] = 1'b0;
               nxt_q.st = D_RXTURN;
            end
            else
               nxt_q.cnt = q_ff.cnt + 16'h1;
         end
         D_RXTURN:
         begin
            nxt_q.dir = 1'b1;
            nxt_q.st = D_RXDRV;
         end
         D_RXDRV:
         begin
            nxt_q.dout = {6'h00, q_ff.ls_sync[3:2]};
            nxt_q.doe = 1'b1;
            nxt_q.st = D_RDATA;
         end
         D_SUSP:
         begin
            if (ulpi.stp)
            begin
               nxt_q.fc[UFC_SUSP_BIT] = 1'b1;
               nxt_q.dir = 1'b0;
               nxt_q.lp = 1'b0;
               nxt_q.st = D_IDLE;
            end
         end
         default:
            nxt_q.st = D_IDLE;
      endcase
      spd = nxt_q.fc[UFC_SPD_LSB +: 2];
      opm = nxt_q.fc[UFC_OPM_LSB +: 2];
      live = !nxt_q.lp;
      nxt_q.hs = live && (spd == UFC_SPD_HS);
      nxt_q.fs = live && (spd == UFC_SPD_FS || spd == UFC_SPD_FSLS);
      nxt_q.ls = live && (spd == UFC_SPD_LS);
      nxt_q.pre = live && (spd == UFC_SPD_FSLS);
      nxt_q.nd = (opm == UFC_OPM_NODRV);
      nxt_q.raw = (opm == UFC_OPM_RAW);
      nxt_q.nse = (opm == UFC_OPM_NOSYNC);
      // pull-up off when non-driving or both pulldowns on
      nxt_q.pu = live && nxt_q.fc[UFC_TERM_BIT] && (spd != UFC_SPD_HS) && (opm != UFC_OPM_NODRV)
                 && !(plus_line_pulldown_enable && minus_line_pulldown_enable);
      // hs terminations in hs with select low and a driving opmode
      nxt_q.ht = live && !nxt_q.fc[UFC_TERM_BIT] && (spd == UFC_SPD_HS) && (opm != UFC_OPM_NODRV);
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   // powered, full-speed after reset
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         q_ff <= '0;
         q_ff.fc <= UFC_RESET_VAL;
         q_ff.fs <= 1'b1;
      end
      else if (ce)
         q_ff <= nxt_q;
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign ulpi.dir = q_ff.dir;
   assign ulpi.nxt = q_ff.nxt;
   assign ulpi.phy_dout = q_ff.dout;
   assign ulpi.phy_doe = q_ff.doe;
   assign phy_function_control = q_ff.fc;
   assign low_power = q_ff.lp;
   assign core_reset = q_ff.crst;
   // fs receiver is never powered down
   assign fs_rx_en = 1'b1;
   assign hs_xcvr_en = q_ff.hs;
   assign fs_xcvr_en = q_ff.fs;
   assign ls_xcvr_en = q_ff.ls;
   assign fs_preamble_en = q_ff.pre;
   assign tx_non_driving = q_ff.nd;
   assign tx_raw_encoding = q_ff.raw;
   assign tx_no_sync_eop = q_ff.nse;
   assign fs_pullup_en = q_ff.pu;
   assign hs_term_en = q_ff.ht;
endmodule

// File: verification/ufc_chk.sv
// checks on the link wires and the transceiver end outputs
// assumes one clock hclk and reset hresetn, async active low
`timescale 1ns/1ps
module ufc_chk
   import ufc_pkg::*;
(
   input wire logic       hclk,
   input wire logic       hresetn,
   input wire logic       dir,
   input wire logic       nxt,
   input wire logic       stp,
   input wire logic       link_doe,
   input wire logic [7:0] phy_function_control,
   input wire logic       low_power,
   input wire logic       core_reset,
   input wire logic       fs_rx_en,
   input wire logic       hs_xcvr_en,
   input wire logic       fs_xcvr_en,
   input wire logic       ls_xcvr_en,
   input wire logic       fs_preamble_en,
   input wire logic       tx_non_driving,
   input wire logic       tx_raw_encoding,
   input wire logic       tx_no_sync_eop,
   input wire logic       fs_pullup_en,
   input wire logic       hs_term_en,
   input wire logic       plus_line_pulldown_enable,
   input wire logic       minus_line_pulldown_enable
);
   logic [7:0] fc;
   logic [1:0] spd;
   logic [1:0] opm;
   logic       pd2;
   assign fc  = phy_function_control;
   assign spd = fc[1:0];
   assign opm = fc[4:3];
   assign pd2 = plus_line_pulldown_enable & minus_line_pulldown_enable;
   // ----------------------------------------
   // properties
   // ----------------------------------------
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // dir gap then turnaround and status byte
   sequence s_rxcmd;
      !dir ##1 dir ##[1:2] !dir;
   endsequence
   property p_rst_val;
      $rose(hresetn) |-> fc == UFC_RESET_VAL;
   endproperty
   a_rst_val: assert property (p_rst_val) else $error("reset value wrong");
   property p_cmd_ack;
      $rose(link_doe) && !dir |-> ##1 nxt;
   endproperty
   a_cmd_ack: assert property (p_cmd_ack) else $error("command not acknowledged");
   property p_lp_enter;
      $fell(fc[UFC_SUSP_BIT]) |-> ##[0:4] low_power;
   endproperty
   a_lp_enter: assert property (p_lp_enter) else $error("low power not entered");
   property p_lp_off;
      low_power |-> fs_rx_en && !hs_xcvr_en && !fs_xcvr_en && !ls_xcvr_en;
   endproperty
   a_lp_off: assert property (p_lp_off) else $error("block powered in low power");
   property p_wake;
      low_power && stp |-> ##[1:3] (fc[UFC_SUSP_BIT] && !low_power);
   endproperty
   a_wake: assert property (p_wake) else $error("wake did not restore suspend bit");
   property p_xrst_go;
      $rose(fc[UFC_XRST_BIT]) |-> ##[1:4] (dir && core_reset);
   endproperty
   a_xrst_go: assert property (p_xrst_go) else $error("core reset not started");
   // register bits 4:0 must survive the core reset
   property p_xrst_keep;
      core_reset && $past(core_reset) |-> $stable(fc[4:0]);
   endproperty
   a_xrst_keep: assert property (p_xrst_keep) else $error("register changed in core reset");
   property p_xrst_end;
      $fell(core_reset) |-> ##[0:3] !fc[UFC_XRST_BIT];
   endproperty
   a_xrst_end: assert property (p_xrst_end) else $error("reset bit not cleared");
   property p_rxcmd;
      $fell(core_reset) |-> ##[0:2] s_rxcmd;
   endproperty
   a_rxcmd: assert property (p_rxcmd) else $error("no status update after reset");
   property p_spd;
      !low_power |-> {hs_xcvr_en, fs_xcvr_en, ls_xcvr_en, fs_preamble_en} ==
         {spd == UFC_SPD_HS, spd[0], spd == UFC_SPD_LS, spd == UFC_SPD_FSLS};
   endproperty
   a_spd: assert property (p_spd) else $error("speed decode wrong");
   property p_opm;
      {tx_non_driving, tx_raw_encoding, tx_no_sync_eop} ==
         {opm == UFC_OPM_NODRV, opm == UFC_OPM_RAW, opm == UFC_OPM_NOSYNC};
   endproperty
   a_opm: assert property (p_opm) else $error("mode decode wrong");
   // outputs are flops, so only judged once inputs have settled
   property p_term;
      $stable(fc) && $stable(low_power) && $stable(pd2) |->
         fs_pullup_en == (!low_power && fc[UFC_TERM_BIT] && spd != UFC_SPD_HS && opm != UFC_OPM_NODRV && !pd2)
         && hs_term_en == (!low_power && !fc[UFC_TERM_BIT] && spd == UFC_SPD_HS && opm != UFC_OPM_NODRV);
   endproperty
   a_term: assert property (p_term) else $error("termination wrong");
   property p_yield;
      dir && $past(dir) |-> !link_doe;
   endproperty
   a_yield: assert property (p_yield) else $error("link drives while dir high");
endmodule

// File: verification/ulpi_phy_function_control_test.sv
// self-checking bench: both ends joined, orders given over ahb-lite
// assumes one clock; link transfers are polled through the status word
`timescale 1ns/1ps
module ulpi_phy_function_control_test;
   import ufc_pkg::*;
   logic        hclk;
   logic        hresetn;
   logic        ce;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic        hreadyout;
   logic        hresp;
   logic [31:0] hrdata;
   logic [1:0]  line_state;
   logic        plus_line_pulldown_enable;
   logic        minus_line_pulldown_enable;
   logic [7:0]  fc;
   wire  [11:0] outs;
   logic [31:0] exp_q[$];
   string       nm_q[$];
   logic [31:0] seen_v;
   event        res_ev;
   int          err_total;
   int          n_checks;
   logic [7:0]  rb;
   logic [7:0]  sh;
   logic [7:0]  d;
   logic [31:0] st;
   logic        saw_crst = 1'b0;
   // ----------------------------------------
   // design and checker
   // ----------------------------------------
   ufc_ulpi_if u_ufc_ulpi_if (.hclk(hclk));
   ufc_link u_ufc_link (.hclk(hclk), .hresetn(hresetn), .ce(ce), .ulpi(u_ufc_ulpi_if), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
   // short core reset keeps the run brief
   ufc_phy #(.CRST_CYC(2)) u_ufc_phy (.hclk(hclk), .hresetn(hresetn), .ce(ce), .ulpi(u_ufc_ulpi_if),
      .line_state(line_state), .plus_line_pulldown_enable(plus_line_pulldown_enable),
      .minus_line_pulldown_enable(minus_line_pulldown_enable), .phy_function_control(fc),
      .low_power(outs[11]), .core_reset(outs[10]), .fs_rx_en(outs[9]), .hs_xcvr_en(outs[8]),
      .fs_xcvr_en(outs[7]), .ls_xcvr_en(outs[6]), .fs_preamble_en(outs[5]), .tx_non_driving(outs[4]),
      .tx_raw_encoding(outs[3]), .tx_no_sync_eop(outs[2]), .fs_pullup_en(outs[1]), .hs_term_en(outs[0]));
   ufc_chk u_ufc_chk (.hclk(hclk), .hresetn(hresetn), .dir(u_ufc_ulpi_if.dir), .nxt(u_ufc_ulpi_if.nxt),
      .stp(u_ufc_ulpi_if.stp), .link_doe(u_ufc_ulpi_if.link_doe), .phy_function_control(fc),
      .low_power(outs[11]), .core_reset(outs[10]), .fs_rx_en(outs[9]), .hs_xcvr_en(outs[8]),
      .fs_xcvr_en(outs[7]), .ls_xcvr_en(outs[6]), .fs_preamble_en(outs[5]), .tx_non_driving(outs[4]),
      .tx_raw_encoding(outs[3]), .tx_no_sync_eop(outs[2]), .fs_pullup_en(outs[1]), .hs_term_en(outs[0]),
      .plus_line_pulldown_enable(plus_line_pulldown_enable),
      .minus_line_pulldown_enable(minus_line_pulldown_enable));
   // ----------------------------------------
   // clock, checking and bus tasks
   // ----------------------------------------
   initial
   begin
      hclk = 1'b0;
      forever #50 hclk = ~hclk;
   end
   always @(posedge hclk)
      if (outs[10] === 1'b1) saw_crst <= 1'b1;
   task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic expect_seen(string nm, logic [31:0] exp, logic [31:0] seen);
      nm_q.push_back(nm);
      exp_q.push_back(exp);
      seen_v = seen;
      ->res_ev;
      #1;
   endtask
   initial
   begin
      forever
      begin
         @(res_ev);
         check(nm_q.pop_front(), seen_v, exp_q.pop_front());
      end
   end
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wait_cyc(int n);
      repeat (n) @(posedge hclk);
      #1;
   endtask
   task automatic ahb(logic [7:0] a, logic w, logic [31:0] wd, output logic [31:0] rd);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   // busy is polled; the controller holds it through any core reset
   task automatic link_op(logic [1:0] op, logic [5:0] a, logic [7:0] wd);
      int n;
      ahb(UFC_AHB_CTRL, 1'b1, {14'h0, op, 2'h0, a, wd}, st);
      n = 0;
      do
      begin
         ahb(UFC_AHB_STAT, 1'b0, 32'h0, st);
         n++;
      end
      while (st[0] !== 1'b0 && n < 300);
      if (n == 300) err_total++;
      rb = st[15:8];
   endtask
   function automatic logic [11:0] dec(logic [7:0] r, logic lp);
      logic [1:0] s;
      logic [1:0] o;
      logic       pd;
      s  = r[1:0];
      o  = r[4:3];
      pd = plus_line_pulldown_enable && minus_line_pulldown_enable;
      return {lp, 1'b0, 1'b1, !lp && s == 2'h0, !lp && s[0], !lp && s == 2'h2, !lp && s == 2'h3, o == 2'h1,
         o == 2'h2, o == 2'h3, !lp && r[2] && s != 2'h0 && o != 2'h1 && !pd, !lp && !r[2] && s == 2'h0 && o != 2'h1};
   endfunction
   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial
   begin
      repeat (30000) @(posedge hclk);
      err_total++;
      print_verdict();
   end
   initial
   begin
      hresetn = 1'b0;
      ce = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      line_state = 2'h0;
      plus_line_pulldown_enable = 1'b0;
      minus_line_pulldown_enable = 1'b0;
      err_total = 0;
      n_checks = 0;
      void'($urandom(32'hD28A));
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      line_state <= 2'($urandom);
      wait_cyc(1);
      expect_seen("fctl", 32'(UFC_RESET_VAL), 32'(fc));
      expect_seen("outs", 32'(dec(UFC_RESET_VAL, 1'b0)), 32'(outs));
      for (int a = 4; a <= 6; a++)
      begin
         link_op(UFC_OP_READ, 6'(a), 8'h00);
         expect_seen("rd", 32'(UFC_RESET_VAL), 32'(rb));
      end
      ahb(8'h08, 1'b0, 32'h0, st);
      expect_seen("unmapped", 32'h0, st);
      expect_seen("hresp", 32'h0, 32'(hresp));
      $display("test reset done");
      for (int i = 0; i < 16; i++)
      begin
         @(posedge hclk);
         plus_line_pulldown_enable <= 1'($urandom);
         minus_line_pulldown_enable <= 1'($urandom);
         sh = {3'h2, 2'(i >> 2), 1'($urandom), 2'(i)};
         link_op(UFC_OP_WRITE, UFC_ADDR_WRITE, sh);
         wait_cyc(2);
         expect_seen("fctl", 32'(sh), 32'(fc));
         expect_seen("dec", 32'(dec(sh, 1'b0)), 32'(outs));
      end
      $display("test decode done");
      repeat (4)
      begin
         d = 8'($urandom) & 8'h9F;
         link_op(UFC_OP_WRITE, UFC_ADDR_SET, d);
         sh = sh | d;
         link_op(UFC_OP_READ, UFC_ADDR_WRITE, 8'h00);
         expect_seen("set", 32'(sh), 32'(rb));
         d = 8'($urandom) & 8'h9F;
         link_op(UFC_OP_WRITE, UFC_ADDR_CLEAR, d);
         sh = sh & ~d;
         link_op(UFC_OP_READ, UFC_ADDR_CLEAR, 8'h00);
         expect_seen("clr", 32'(sh), 32'(rb));
      end
      $display("test set clear done");
      link_op(UFC_OP_WRITE, UFC_ADDR_SET, 8'h20);
      wait_cyc(6);
      expect_seen("fctl", 32'(sh), 32'(fc));
      expect_seen("crst", 32'h1, 32'(saw_crst));
      ahb(UFC_AHB_STAT, 1'b0, 32'h0, st);
      expect_seen("rxcmd", 32'({6'h0, line_state}), 32'(st[23:16]));
      $display("test core reset done");
      link_op(UFC_OP_WRITE, UFC_ADDR_CLEAR, 8'h40);
      wait_cyc(4);
      expect_seen("sleep", 32'(dec(sh & 8'hBF, 1'b1)), 32'(outs));
      link_op(UFC_OP_WAKE, 6'h00, 8'h00);
      wait_cyc(2);
      expect_seen("wake", 32'(sh), 32'(fc));
      expect_seen("awake", 32'(dec(sh, 1'b0)), 32'(outs));
      $display("test suspend done");
      link_op(UFC_OP_WRITE, 6'h07, 8'hFF);
      link_op(UFC_OP_READ, 6'h07, 8'h00);
      expect_seen("rd07", 32'h0, 32'(rb));
      expect_seen("fctl", 32'(sh), 32'(fc));
      ce <= 1'b0;
      ahb(UFC_AHB_CTRL, 1'b1, {14'h0, UFC_OP_WRITE, 8'h04, 8'h00}, st);
      ce <= 1'b1;
      ahb(UFC_AHB_STAT, 1'b0, 32'h0, st);
      expect_seen("frozen", 32'h0, 32'(st[0]));
      $display("test other address done");
      print_verdict();
   end
endmodule
